// file: design/data_mem_decoder.sv
// Internal data memory decoder with lower, upper and expanded RAM arrays
`timescale 1ns/1ns

// Contract
// - Lower RAM 00h-7Fh answers to both direct and indirect accesses.
// - Upper RAM 80h-FFh answers to indirect accesses only.
// - Special function registers at 80h-FFh answer to direct accesses only.
// - Upper RAM is an array of its own, apart from the register space.
// - A direct access above 7Fh goes to the register space.
// - An indirect access above 7Fh goes to the upper RAM.
// - External moves below the expanded RAM size are served on chip while the disable bit is clear.
// - The expanded RAM starts at external address zero.
// - The expanded RAM size is configurable up to 1792 bytes.
module data_mem_decoder
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire data_mem_pkg::access_s cpu_access,
  input  wire logic                  onchip_xmem_disable,
  input  wire logic [10:0]           expanded_onchip_ram_size,
  input  wire logic [7:0]            sfr_rdata,
  input  wire logic [7:0]            ext_rdata,
  output logic [7:0]                 cpu_rdata,
  output data_mem_pkg::target_e      last_target,
  output data_mem_pkg::mem_req_s     sfr_req,
  output data_mem_pkg::mem_req_s     ext_req
);

  // ==========================================================
  // Decode
  logic [7:0] lower_ram [0:127];
  logic [7:0] upper_ram [0:127];
  logic [7:0] expanded_onchip_ram      [0:1791];

  wire logic        acc_v     = cpu_access.valid;
  wire logic [15:0] acc_a     = cpu_access.addr;
  wire logic        is_high   = acc_a[7:0] >= data_mem_pkg::UPPER_BASE;
  wire logic        is_direct = cpu_access.mode == data_mem_pkg::MODE_DIRECT;
  wire logic        is_indir  = cpu_access.mode ==
                                data_mem_pkg::MODE_INDIRECT;
  wire logic        is_ext    = cpu_access.mode ==
                                data_mem_pkg::MODE_EXTERNAL;
  // Size clamped so a too-large setting can never index past the array
  wire logic [10:0] xsize     = (expanded_onchip_ram_size > data_mem_pkg::EXPANDED_ONCHIP_RAM_MAX_BYTES) ?
                                data_mem_pkg::EXPANDED_ONCHIP_RAM_MAX_BYTES : expanded_onchip_ram_size;
  wire logic        in_expanded_onchip_ram   = acc_a < {5'h00, xsize};

  // An illegal mode code must not fall into the lower RAM
  wire logic hit_lower = acc_v && (is_direct || is_indir) && !is_high;
  wire logic hit_upper = acc_v && is_indir && is_high;
  wire logic hit_sfr   = acc_v && is_direct && is_high;
  wire logic hit_expanded_onchip_ram  = acc_v && is_ext && !onchip_xmem_disable &&
                         in_expanded_onchip_ram;
  wire logic hit_ext   = acc_v && is_ext && !hit_expanded_onchip_ram;

  wire data_mem_pkg::target_e next_target =
    hit_lower ? data_mem_pkg::TGT_LOWER :
    hit_upper ? data_mem_pkg::TGT_UPPER :
    hit_sfr   ? data_mem_pkg::TGT_SFR   :
    hit_expanded_onchip_ram  ? data_mem_pkg::TGT_EXPANDED_ONCHIP_RAM  :
    hit_ext   ? data_mem_pkg::TGT_EXTBUS : data_mem_pkg::TGT_NONE;

  // Register accesses, and external accesses that miss the expanded RAM, are passed through to their owners
  assign sfr_req.read  = hit_sfr && !cpu_access.write;
  assign sfr_req.write = hit_sfr && cpu_access.write;
  assign sfr_req.addr  = {8'h00, acc_a[7:0]};
  assign sfr_req.wdata = cpu_access.wdata;
  assign ext_req.read  = hit_ext && !cpu_access.write;
  assign ext_req.write = hit_ext && cpu_access.write;
  assign ext_req.addr  = acc_a;
  assign ext_req.wdata = cpu_access.wdata;

  // ==========================================================
  // Storage, physically separate arrays; read data one cycle later
  always_ff @(posedge clk)
  begin
    if (hit_lower && cpu_access.write)
      lower_ram[acc_a[6:0]] <= cpu_access.wdata;
    if (hit_upper && cpu_access.write)
      upper_ram[acc_a[6:0]] <= cpu_access.wdata;
    if (hit_expanded_onchip_ram && cpu_access.write)
      expanded_onchip_ram[acc_a[10:0]] <= cpu_access.wdata;
  end

  logic [7:0] ram_rdata;

  always_ff @(posedge clk)
  begin
    ram_rdata <= hit_lower ? lower_ram[acc_a[6:0]] :
                 hit_upper ? upper_ram[acc_a[6:0]] :
                 hit_expanded_onchip_ram  ? expanded_onchip_ram[acc_a[10:0]] : data_mem_pkg::DATA_RESET;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      last_target <= data_mem_pkg::TGT_NONE;
    else if (acc_v)
      last_target <= next_target;
  end

  // Peripheral read data is sampled with the access, like RAM data
  logic [7:0] port_rdata;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      port_rdata <= data_mem_pkg::DATA_RESET;
    else if (hit_sfr)
      port_rdata <= sfr_rdata;
    else if (hit_ext)
      port_rdata <= ext_rdata;
  end

  wire logic from_port = last_target == data_mem_pkg::TGT_SFR ||
                         last_target == data_mem_pkg::TGT_EXTBUS;
  wire logic from_ram  = last_target == data_mem_pkg::TGT_LOWER ||
                         last_target == data_mem_pkg::TGT_UPPER ||
                         last_target == data_mem_pkg::TGT_EXPANDED_ONCHIP_RAM;
  assign cpu_rdata = from_port ? port_rdata :
                     from_ram  ? ram_rdata  : data_mem_pkg::DATA_RESET;

  // ==========================================================
  // Checks
  property p_lower;
    @(posedge clk) disable iff (rst)
    (acc_v && (is_direct || is_indir) && !is_high) |=>
      last_target == data_mem_pkg::TGT_LOWER;
  endproperty
  a_lower: assert property (p_lower) else $error("lower miss");

  property p_upper_indirect_only;
    @(posedge clk) disable iff (rst)
    hit_upper |-> (is_indir && !sfr_req.read && !sfr_req.write);
  endproperty
  a_upper_indirect_only: assert property (p_upper_indirect_only)
    else $error("upper misuse");

  property p_sfr_direct;
    @(posedge clk) disable iff (rst)
    (sfr_req.read || sfr_req.write) |-> (is_direct && is_high);
  endproperty
  a_sfr_direct: assert property (p_sfr_direct) else $error("sfr mode");

  property p_separate;
    @(posedge clk) disable iff (rst)
    hit_upper |-> !hit_sfr;
  endproperty
  a_separate: assert property (p_separate) else $error("overlap");

  property p_direct_high;
    @(posedge clk) disable iff (rst)
    (acc_v && is_direct && is_high) |=>
      last_target == data_mem_pkg::TGT_SFR;
  endproperty
  a_direct_high: assert property (p_direct_high) else $error("no sfr");

  property p_indirect_high;
    @(posedge clk) disable iff (rst)
    (acc_v && is_indir && is_high) |=>
      last_target == data_mem_pkg::TGT_UPPER;
  endproperty
  a_indirect_high: assert property (p_indirect_high)
    else $error("no upper");

  sequence s_expanded_onchip_ram_access;
    acc_v && is_ext && !onchip_xmem_disable && acc_a == 16'h0000 &&
    xsize != 11'h000;
  endsequence
  property p_expanded_onchip_ram_zero;
    @(posedge clk) disable iff (rst)
    s_expanded_onchip_ram_access |-> !ext_req.read && !ext_req.write ##1
      last_target == data_mem_pkg::TGT_EXPANDED_ONCHIP_RAM;
  endproperty
  a_expanded_onchip_ram_zero: assert property (p_expanded_onchip_ram_zero) else $error("expanded_onchip_ram zero");

  property p_expanded_onchip_ram_limit;
    @(posedge clk) disable iff (rst)
    hit_expanded_onchip_ram |-> acc_a < 16'h0700;
  endproperty
  a_expanded_onchip_ram_limit: assert property (p_expanded_onchip_ram_limit) else $error("expanded_onchip_ram size");

  property p_ext_fwd;
    @(posedge clk) disable iff (rst)
    (acc_v && is_ext && (onchip_xmem_disable || !in_expanded_onchip_ram)) |->
      (ext_req.read || ext_req.write) ##1
      last_target == data_mem_pkg::TGT_EXTBUS;
  endproperty
  a_ext_fwd: assert property (p_ext_fwd) else $error("no ext fwd");

  // ==========================================================
  // Read data returned by the owners of forwarded accesses
  sequence s_reg_read;
    hit_sfr && !cpu_access.write;
  endsequence
  property p_reg_rdata;
    @(posedge clk) disable iff (rst)
    s_reg_read |=> cpu_rdata == $past(sfr_rdata);
  endproperty
  a_reg_rdata: assert property (p_reg_rdata) else $error("reg rdata");

  sequence s_bus_read;
    hit_ext && !cpu_access.write;
  endsequence
  property p_bus_rdata;
    @(posedge clk) disable iff (rst)
    s_bus_read |=> cpu_rdata == $past(ext_rdata);
  endproperty
  a_bus_rdata: assert property (p_bus_rdata) else $error("bus rdata");

  // An illegal mode code reaches no region and returns zero
  property p_bad_mode;
    @(posedge clk) disable iff (rst)
    (acc_v && !is_direct && !is_indir && !is_ext) |=>
      (last_target == data_mem_pkg::TGT_NONE &&
       cpu_rdata == data_mem_pkg::DATA_RESET);
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("bad mode");

  // Nothing is forwarded while no access is presented
  property p_idle_quiet;
    @(posedge clk) disable iff (rst)
    !acc_v |-> !(sfr_req.read || sfr_req.write ||
                 ext_req.read || ext_req.write);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle strobe");

endmodule

// file: design/data_mem_pkg.sv
// Package: address map, access modes and access carrier for the decoder
package data_mem_pkg;

  localparam logic [7:0]  LOWER_RAM_LAST   = 8'h7F;
  localparam logic [7:0]  UPPER_BASE       = 8'h80;
  localparam logic [10:0] EXPANDED_ONCHIP_RAM_MAX_BYTES   = 11'h700;
  localparam logic [10:0] EXPANDED_ONCHIP_RAM_SIZE_RESET  = 11'h700;
  localparam logic        XMEM_DIS_RESET   = 1'b0;
  localparam logic [7:0]  DATA_RESET       = 8'h00;

  typedef enum logic [1:0]
  {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_EXTERNAL
  } access_mode_e;

  typedef enum logic [2:0]
  {
    TGT_NONE,
    TGT_LOWER,
    TGT_UPPER,
    TGT_SFR,
    TGT_EXPANDED_ONCHIP_RAM,
    TGT_EXTBUS
  } target_e;

  typedef struct packed
  {
    logic         valid;
    logic         write;
    access_mode_e mode;
    logic [15:0]  addr;
    logic [7:0]   wdata;
  } access_s;

  typedef struct packed
  {
    logic        read;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

endpackage

// file: verif/far_side_model.sv
// Far-side model: register file and external bus read data
`timescale 1ns/1ns
module far_side_model
(
  input  wire data_mem_pkg::mem_req_s sfr_req,
  input  wire data_mem_pkg::mem_req_s ext_req,
  output logic [7:0]                  sfr_rdata,
  output logic [7:0]                  ext_rdata
);
  // Off-read cycles show inverted data so a stale value never looks right
  assign sfr_rdata = sfr_req.read ? sfr_req.addr[7:0] ^ 8'h5A : ~sfr_req.addr[7:0];
  assign ext_rdata = ext_req.read ? ext_req.addr[7:0] ^ 8'hC3 : ~ext_req.addr[7:0];
endmodule

// file: verif/tb_internal_data_memory_decoder.sv
// Testbench for the internal data memory decoder
`timescale 1ns/1ns
module tb_internal_data_memory_decoder;
  localparam data_mem_pkg::access_mode_e dr = data_mem_pkg::MODE_DIRECT;
  localparam data_mem_pkg::access_mode_e ir = data_mem_pkg::MODE_INDIRECT;
  localparam data_mem_pkg::access_mode_e xr = data_mem_pkg::MODE_EXTERNAL;
  localparam data_mem_pkg::target_e      lo = data_mem_pkg::TGT_LOWER;
  localparam data_mem_pkg::target_e      up = data_mem_pkg::TGT_UPPER;
  localparam data_mem_pkg::target_e      sf = data_mem_pkg::TGT_SFR;
  localparam data_mem_pkg::target_e      xm = data_mem_pkg::TGT_EXPANDED_ONCHIP_RAM;
  localparam data_mem_pkg::target_e      eb = data_mem_pkg::TGT_EXTBUS;
  logic                   clk;
  logic                   rst;
  data_mem_pkg::access_s  ca;
  logic                   xdis;
  logic [10:0]            xsize;
  logic [7:0]             sfr_rdata;
  logic [7:0]             ext_rdata;
  logic [7:0]             cpu_rdata;
  data_mem_pkg::target_e  last_target;
  data_mem_pkg::mem_req_s sfr_req;
  data_mem_pkg::mem_req_s ext_req;
  int                     num_errors;
  int                     total_checks;

  data_mem_decoder dut_u (.clk(clk), .rst(rst), .cpu_access(ca),
    .onchip_xmem_disable(xdis), .expanded_onchip_ram_size(xsize), .sfr_rdata(sfr_rdata),
    .ext_rdata(ext_rdata), .cpu_rdata(cpu_rdata),
    .last_target(last_target), .sfr_req(sfr_req), .ext_req(ext_req));
  far_side_model far_u (.sfr_req(sfr_req), .ext_req(ext_req),
    .sfr_rdata(sfr_rdata), .ext_rdata(ext_rdata));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // One access, back to back; strobes sampled before the taking edge
  task automatic acc(input data_mem_pkg::access_mode_e m, input logic w,
    input logic [15:0] a, input logic [7:0] d, input data_mem_pkg::target_e t,
    input logic [7:0] r, input logic [1:0] s);
    logic [1:0] seen;
    ca = '{1'b1, w, m, a, d};
    #2;
    seen = {sfr_req.read | sfr_req.write, ext_req.read | ext_req.write};
    @(posedge clk);
    #1;
    chk("strobes", {14'h0, seen}, {14'h0, s});
    chk("target", {13'h0, last_target}, {13'h0, t});
    if (!w) chk("rdata", {8'h0, cpu_rdata}, {8'h0, r});
  endtask

  task automatic t_lower();
    acc(dr, 1'b1, 16'h0005, 8'h3C, lo, 8'h00, 2'b00);
    acc(ir, 0, 16'h0005, 8'h00, lo, 8'h3C, 2'b00);
    acc(ir, 1'b1, 16'h007F, 8'hA5, lo, 8'h00, 2'b00);
    acc(dr, 0, 16'h007F, 8'h00, lo, 8'hA5, 2'b00);
    $display("test lower done");
  endtask

  task automatic t_upper();
    acc(ir, 1'b1, 16'h00A0, 8'h66, up, 8'h00, 2'b00);
    acc(dr, 0, 16'h00A0, 8'h00, sf, 8'hFA, 2'b10);
    acc(dr, 1'b1, 16'h00A0, 8'h11, sf, 8'h00, 2'b10);
    acc(ir, 0, 16'h00A0, 8'h00, up, 8'h66, 2'b00);
    $display("test upper done");
  endtask

  task automatic t_expanded_onchip_ram();
    acc(xr, 1'b1, 16'h0000, 8'h77, xm, 8'h00, 2'b00);
    acc(xr, 1'b1, 16'h06FF, 8'h99, xm, 8'h00, 2'b00);
    acc(xr, 0, 16'h0000, 8'h00, xm, 8'h77, 2'b00);
    acc(xr, 0, 16'h06FF, 8'h00, xm, 8'h99, 2'b00);
    acc(xr, 0, 16'h0700, 8'h00, eb, 8'hC3, 2'b01);
    $display("test expanded_onchip_ram done");
  endtask

  task automatic t_extbus();
    xsize = 11'h010;
    acc(xr, 0, 16'h0010, 8'h00, eb, 8'hD3, 2'b01);
    acc(xr, 1'b1, 16'h000F, 8'h01, xm, 8'h00, 2'b00);
    xdis = 1'b1;
    acc(xr, 0, 16'h0000, 8'h00, eb, 8'hC3, 2'b01);
    xdis = 1'b0;
    acc(xr, 0, 16'h0000, 8'h00, xm, 8'h77, 2'b00);
    acc(data_mem_pkg::access_mode_e'(2'b11), 0, 16'h0005, 8'h00,
      data_mem_pkg::TGT_NONE, 8'h00, 2'b00);
    ca.valid = 1'b0;
    $display("test extbus done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    num_errors = 0;
    total_checks = 0;
    rst = 1'b1;
    ca = '0;
    xdis = 1'b0;
    xsize = 11'h700;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_lower();
    t_upper();
    t_expanded_onchip_ram();
    t_extbus();
    wrap_up();
  end
endmodule
